// ===== src/smc_mgmt_regs.sv
// MDIO slave and management register bank of the serdes
`timescale 1ns/1ns
// How it works
// - Writing 0 to receive reset bit resets rx logic; bit self-restores to 1.
// - Writing 0 to transmit reset bit resets tx logic; bit self-restores to 1.
// - Without reference clock, triggered resets hold and bits stay 0.
// - Frame-loss bypass bit disables frame-loss supervision; resets to 0.
// - Receive equalization field applies only while both select pins are low.
// - Upper byte of de-emphasis register sets hyperframe length; resets to 20h.
// - Tx_deemphasis_ctrl field applies only while both select pins are low.
// - Loopback field: 0000 normal, xxx1 local, xx10 line.
// - Loopback 1000 special local, 0100 special line, 1100 digital.
// - Undefined loopback codes give normal operation.
// - Management-required register reads 10 in top bits.
// - Receive output enable drives parallel outputs while the rx verifier (bit 9) is enabled.
// - Bit 9 enables rx verifier, bit 8 tx generator, independently.
// - Rx pattern: 00/11 compliance jitter, 01 pseudo-random, 10 reserved.
// - Tx pattern: 00/11 compliance jitter, 01 pseudo-random, 10 reserved.
// - Reserved bits read undefined; here they read zero.
// - Second identifier word: vendor high bits, part number, revision, read-only.
// - Identifier words mirrored at 0Eh and 0Fh.
// - Reset bits are write-and-clear; software re-reads to confirm restore.
// - Read: release line in first turnaround bit, drive 0 in second, then data.
// - Wrong port, right device reads all ones; right port, wrong device zeros.
module smc_mgmt_regs import smc_pkg::*; (
    input wire logic clock, // system clock
    input wire logic rst, // synchronous reset, active high
    input wire logic device_reset_pin_n, // device reset pin, low resets bank
    input wire logic reference_input_clock, // reference clock, sampled
    input wire logic mdc, // management clock, sampled
    input wire logic mdio_in, // management data in
    output logic mdio_out, // management data out
    output logic mdio_oe, // management data drive enable
    input wire logic [1:0] equalization_select_pins, // eq pins
    input wire logic [1:0] deemphasis_select_pins, // de-emphasis pins
    output logic rx_logic_reset_n, // rx logic reset, low active
    output logic tx_logic_reset_n, // tx logic reset, low active
    output logic frame_loss_bypass, // disables frame-loss supervision
    output logic [1:0] rx_equalization_level, // equalizer setting
    output logic [1:0] tx_deemphasis_level, // de-emphasis setting
    output logic [7:0] hyperframe_length, // non-standard hyperframe length
    output smc_loop_mode_t loop_mode, // decoded loopback mode
    output smc_self_test_t self_test, // self-test controls
    output logic rx_parallel_out_en // rx parallel output pins enable
);
    typedef enum {SMC_IDLE, SMC_PRE, SMC_HDR, SMC_TA, SMC_DATA} smc_state_t;

    logic bank_rst;
    assign bank_rst = rst || !device_reset_pin_n;

    // Register storage
    logic [15:0] rx_equalization_level_reg, rx_equalization_level_next, tx_deemphasis_level_reg, tx_deemphasis_level_next;
    logic [15:0] loop_reg, loop_next, st_reg, st_next;

    // Frame engine
    smc_state_t state_reg, state_next;
    logic [5:0] cnt_reg, cnt_next;
    logic [16:0] hdr_reg, hdr_next, hdr_shift;
    logic [15:0] sh_reg, sh_next;
    logic mdc_d_reg, ref_d_reg, ref_d2_reg;
    logic [3:0] ref_cnt_reg, ref_cnt_next;
    logic mdio_out_next, mdio_oe_next;
    logic rx_clr, tx_clr, wr_commit;
    logic rx_rst_bit, tx_rst_bit;
    logic mdc_rise, mdc_fall;
    logic ref_ok;

    assign mdc_rise = mdc && !mdc_d_reg;
    assign mdc_fall = !mdc && mdc_d_reg;
    assign ref_ok = ref_cnt_reg != SMC_REF_TIMEOUT;

    // Header fields: op[16:15] port[14:10] dev[9:5] reg[4:0]; start already matched
    logic [1:0] h_op;
    logic [4:0] h_port, h_dev, h_ofs;
    assign h_op = hdr_reg[16:15];
    assign h_port = hdr_reg[14:10];
    assign h_dev = hdr_reg[9:5];
    assign h_ofs = hdr_reg[4:0];
    assign hdr_shift = {hdr_reg[15:0], mdio_in};

    function automatic logic [15:0] read_word(input logic [4:0] ofs);
        case (ofs)
            SMC_OFS_VENDOR_ID, SMC_OFS_VENDOR_ID_M: read_word = SMC_VENDOR_ID;
            SMC_OFS_VENDOR_PART, SMC_OFS_VENDOR_PART_M:
                read_word = {SMC_VENDOR_HI, SMC_PART_NUM, SMC_REVISION};
            SMC_OFS_RESET: begin
                read_word = 16'h0000;
                read_word[SMC_RX_RST_BIT] = rx_rst_bit;
                read_word[SMC_TX_RST_BIT] = tx_rst_bit;
            end
            SMC_OFS_RX_EQUALIZATION_LEVEL: read_word = rx_equalization_level_reg & 16'h8003;
            SMC_OFS_TX_DEEMPHASIS_LEVEL: read_word = tx_deemphasis_level_reg & 16'hff03;
            SMC_OFS_LOOPBACK: read_word = loop_reg & 16'h000f;
            SMC_OFS_MGMT_REQ: read_word = SMC_MGMT_REQ_VAL;
            SMC_OFS_SELF_TEST: read_word = st_reg & 16'h0733;
            default: read_word = 16'h0000;
        endcase
    endfunction

    // Read word chosen on the last header bit, from the full header
    logic [15:0] rd_word;
    always_comb begin
        rd_word = SMC_ALL_ZEROS;
        if (hdr_shift[9:5] == SMC_DEV_ADDR) begin
            rd_word = (hdr_shift[14:10] == SMC_PORT_ADDR) ? read_word(hdr_shift[4:0]) : SMC_ALL_ONES;
        end
    end

    // Frame engine next state
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        hdr_next = hdr_reg;
        sh_next = sh_reg;
        mdio_out_next = mdio_out;
        mdio_oe_next = mdio_oe;
        wr_commit = 1'b0;
        if (mdc_rise) begin
            case (state_reg)
                SMC_IDLE: begin
                    if (!mdio_in) begin
                        state_next = SMC_PRE;
                    end
                end
                SMC_PRE: begin
                    state_next = mdio_in ? SMC_HDR : SMC_IDLE;
                    cnt_next = 6'd0;
                end
                SMC_HDR: begin
                    hdr_next = hdr_shift;
                    cnt_next = cnt_reg + 6'd1;
                    if (cnt_reg == SMC_HDR_BITS - 6'd1) begin
                        state_next = SMC_TA;
                        cnt_next = 6'd0;
                        // Captured once, so the word cannot tear while it is shifted out
                        sh_next = rd_word;
                    end
                end
                SMC_TA: begin
                    cnt_next = cnt_reg + 6'd1;
                    if (cnt_reg == 6'd1) begin
                        state_next = SMC_DATA;
                        cnt_next = 6'd0;
                    end
                end
                SMC_DATA: begin
                    cnt_next = cnt_reg + 6'd1;
                    if (h_op == SMC_OP_WRITE) begin
                        sh_next = {sh_reg[14:0], mdio_in};
                    end
                    if (cnt_reg == 6'd15) begin
                        state_next = SMC_IDLE;
                        mdio_oe_next = 1'b0;
                        // Commit on the last data bit only, never mid-frame
                        wr_commit = h_op == SMC_OP_WRITE && h_port == SMC_PORT_ADDR
                            && h_dev == SMC_DEV_ADDR;
                    end
                end
                default: state_next = SMC_IDLE;
            endcase
        end
        // Device drives after the falling edge so the station samples settled data
        if (mdc_fall) begin
            if (state_reg == SMC_TA && cnt_reg == 6'd1 && h_op == SMC_OP_READ) begin
                mdio_oe_next = 1'b1;
                mdio_out_next = 1'b0;
            end else if (state_reg == SMC_DATA && mdio_oe) begin
                mdio_out_next = sh_reg[15];
                sh_next = {sh_reg[14:0], 1'b0};
            end else begin
                mdio_oe_next = 1'b0;
                mdio_out_next = 1'b0;
            end
        end
    end

    // Register next values
    logic [15:0] wr_data;
    assign wr_data = {sh_reg[14:0], mdio_in};
    always_comb begin
        rx_equalization_level_next = rx_equalization_level_reg;
        tx_deemphasis_level_next = tx_deemphasis_level_reg;
        loop_next = loop_reg;
        st_next = st_reg;
        rx_clr = 1'b0;
        tx_clr = 1'b0;
        if (wr_commit) begin
            case (h_ofs)
                SMC_OFS_RESET: begin
                    rx_clr = !wr_data[SMC_RX_RST_BIT];
                    tx_clr = !wr_data[SMC_TX_RST_BIT];
                end
                SMC_OFS_RX_EQUALIZATION_LEVEL: rx_equalization_level_next = wr_data;
                SMC_OFS_TX_DEEMPHASIS_LEVEL: tx_deemphasis_level_next = wr_data;
                SMC_OFS_LOOPBACK: loop_next = wr_data;
                SMC_OFS_SELF_TEST: st_next = wr_data;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (bank_rst) begin
            state_reg <= SMC_IDLE;
            cnt_reg <= 6'd0;
            hdr_reg <= 17'h00000;
            sh_reg <= 16'h0000;
            mdio_out <= 1'b0;
            mdio_oe <= 1'b0;
            rx_equalization_level_reg <= SMC_RX_EQUALIZATION_LEVEL_RST;
            tx_deemphasis_level_reg <= SMC_TX_DEEMPHASIS_LEVEL_RST;
            loop_reg <= SMC_LOOPBACK_RST;
            st_reg <= SMC_SELF_TEST_RST;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            hdr_reg <= hdr_next;
            sh_reg <= sh_next;
            mdio_out <= mdio_out_next;
            mdio_oe <= mdio_oe_next;
            rx_equalization_level_reg <= rx_equalization_level_next;
            tx_deemphasis_level_reg <= tx_deemphasis_level_next;
            loop_reg <= loop_next;
            st_reg <= st_next;
        end
    end

    // Sampling flops for mdc and the reference clock; reference loss timeout
    always_comb begin
        ref_cnt_next = ref_cnt_reg;
        if (ref_d_reg != ref_d2_reg) begin
            ref_cnt_next = 4'h0;
        end else if (ref_cnt_reg != SMC_REF_TIMEOUT) begin
            ref_cnt_next = ref_cnt_reg + 4'h1;
        end
    end
    always_ff @(posedge clock) begin
        if (rst) begin
            mdc_d_reg <= 1'b0;
            ref_d_reg <= 1'b0;
            ref_d2_reg <= 1'b0;
            ref_cnt_reg <= 4'h0;
        end else begin
            mdc_d_reg <= mdc;
            ref_d_reg <= reference_input_clock;
            ref_d2_reg <= ref_d_reg;
            ref_cnt_reg <= ref_cnt_next;
        end
    end

    smc_logic_reset u_rx_rst (
        .clock(clock),
        .rst(bank_rst),
        .clear_req(rx_clr),
        .ref_ok(ref_ok),
        .bit_reg(rx_rst_bit)
    );
    smc_logic_reset u_tx_rst (
        .clock(clock),
        .rst(bank_rst),
        .clear_req(tx_clr),
        .ref_ok(ref_ok),
        .bit_reg(tx_rst_bit)
    );

    // Decoded outputs
    smc_loop_mode_t lb_next;
    smc_self_test_t st_dec;
    function automatic smc_pattern_t pat_dec(input logic [1:0] code);
        case (code)
            2'b01: pat_dec = SMC_PAT_PRWS;
            2'b10: pat_dec = SMC_PAT_RESERVED;
            default: pat_dec = SMC_PAT_COMPLIANCE_JITTER_PATTERN;
        endcase
    endfunction
    always_comb begin
        casez (loop_reg[3:0])
            4'b???1: lb_next = SMC_LB_LOCAL;
            4'b??10: lb_next = SMC_LB_LINE;
            4'b1000: lb_next = SMC_LB_SPEC_LOCAL;
            4'b0100: lb_next = SMC_LB_SPEC_LINE;
            4'b1100: lb_next = SMC_LB_DIGITAL;
            default: lb_next = SMC_LB_NORMAL;
        endcase
        st_dec.rx_verify_en = st_reg[SMC_RX_ST_EN_BIT];
        st_dec.tx_gen_en = st_reg[SMC_TX_ST_EN_BIT];
        st_dec.rx_out_en = st_reg[SMC_RX_OE_BIT];
        st_dec.rx_pattern = pat_dec(st_reg[5:4]);
        st_dec.tx_pattern = pat_dec(st_reg[1:0]);
    end
    always_ff @(posedge clock) begin
        if (bank_rst) begin
            rx_logic_reset_n <= 1'b0;
            tx_logic_reset_n <= 1'b0;
            frame_loss_bypass <= 1'b0;
            rx_equalization_level <= 2'b00;
            tx_deemphasis_level <= 2'b00;
            hyperframe_length <= SMC_TX_DEEMPHASIS_LEVEL_RST[15:8];
            loop_mode <= SMC_LB_NORMAL;
            self_test <= '0;
            rx_parallel_out_en <= 1'b0;
        end else begin
            rx_logic_reset_n <= rx_rst_bit;
            tx_logic_reset_n <= tx_rst_bit;
            frame_loss_bypass <= rx_equalization_level_reg[SMC_FL_BYPASS_BIT];
            rx_equalization_level <= (equalization_select_pins == 2'b00) ? rx_equalization_level_reg[1:0]
                : equalization_select_pins;
            tx_deemphasis_level <= (deemphasis_select_pins == 2'b00) ? tx_deemphasis_level_reg[1:0]
                : deemphasis_select_pins;
            hyperframe_length <= tx_deemphasis_level_reg[15:8];
            loop_mode <= lb_next;
            self_test <= st_dec;
            rx_parallel_out_en <= st_dec.rx_out_en && st_dec.rx_verify_en;
        end
    end

    property p_fl_bypass;
        @(posedge clock) disable iff (bank_rst)
            $past(bank_rst) || frame_loss_bypass == $past(rx_equalization_level_reg[SMC_FL_BYPASS_BIT]);
    endproperty
    a_fl_bypass: assert property (p_fl_bypass) else $error("bypass mismatch");
    property p_eq_pins;
        @(posedge clock) disable iff (bank_rst)
            !$past(bank_rst) && $past(equalization_select_pins) != 2'b00
                |-> rx_equalization_level == $past(equalization_select_pins);
    endproperty
    a_eq_pins: assert property (p_eq_pins) else $error("eq pins ignored");
    property p_loop_digital;
        @(posedge clock) disable iff (bank_rst) $past(loop_reg[3:0]) == 4'b1100 |-> loop_mode == SMC_LB_DIGITAL;
    endproperty
    a_loop_digital: assert property (p_loop_digital) else $error("digital loopback");
    property p_rx_restore;
        @(posedge clock) disable iff (bank_rst) $rose(rx_rst_bit) |=> rx_logic_reset_n;
    endproperty
    a_rx_restore: assert property (p_rx_restore) else $error("rx reset not released");
    property p_tx_restore;
        @(posedge clock) disable iff (bank_rst) $rose(tx_rst_bit) |=> tx_logic_reset_n;
    endproperty
    a_tx_restore: assert property (p_tx_restore) else $error("tx reset not released");
endmodule // smc_mgmt_regs

// ===== src/smc_pkg.sv
// Package: register map, field layout, codes and timing for the serdes management bank
package smc_pkg;
    // MDIO frame fields
    localparam logic [1:0] SMC_START = 2'b01;
    localparam logic [1:0] SMC_OP_WRITE = 2'b01;
    localparam logic [1:0] SMC_OP_READ = 2'b11;
    localparam logic [4:0] SMC_PORT_ADDR = 5'h01;
    localparam logic [4:0] SMC_DEV_ADDR = 5'h1e;
    // Header bits after the start pattern: op, port, device, register
    localparam logic [5:0] SMC_HDR_BITS = 6'd17;
    localparam logic [5:0] SMC_FRAME_BITS = 6'd32;
    localparam logic [15:0] SMC_ALL_ONES = 16'hffff;
    localparam logic [15:0] SMC_ALL_ZEROS = 16'h0000;
    // Register offsets
    localparam logic [4:0] SMC_OFS_VENDOR_ID = 5'h02;
    localparam logic [4:0] SMC_OFS_VENDOR_PART = 5'h03;
    localparam logic [4:0] SMC_OFS_RESET = 5'h04;
    localparam logic [4:0] SMC_OFS_RX_EQUALIZATION_LEVEL = 5'h05;
    localparam logic [4:0] SMC_OFS_TX_DEEMPHASIS_LEVEL = 5'h06;
    localparam logic [4:0] SMC_OFS_LOOPBACK = 5'h07;
    localparam logic [4:0] SMC_OFS_MGMT_REQ = 5'h08;
    localparam logic [4:0] SMC_OFS_SELF_TEST = 5'h09;
    localparam logic [4:0] SMC_OFS_VENDOR_ID_M = 5'h0e;
    localparam logic [4:0] SMC_OFS_VENDOR_PART_M = 5'h0f;
    // Field positions
    localparam int SMC_RX_RST_BIT = 8;
    localparam int SMC_TX_RST_BIT = 0;
    localparam int SMC_FL_BYPASS_BIT = 15;
    localparam int SMC_RX_OE_BIT = 10;
    localparam int SMC_RX_ST_EN_BIT = 9;
    localparam int SMC_TX_ST_EN_BIT = 8;
    // Reset values
    localparam logic [15:0] SMC_RESET_RST = 16'hffff;
    localparam logic [15:0] SMC_RX_EQUALIZATION_LEVEL_RST = 16'h0000;
    localparam logic [15:0] SMC_TX_DEEMPHASIS_LEVEL_RST = 16'h2000;
    localparam logic [15:0] SMC_LOOPBACK_RST = 16'h0000;
    localparam logic [15:0] SMC_MGMT_REQ_VAL = 16'h8000;
    localparam logic [15:0] SMC_SELF_TEST_RST = 16'h0000;
    // Identity fields, values arbitrary
    localparam logic [15:0] SMC_VENDOR_ID = 16'h1234;
    localparam logic [5:0] SMC_VENDOR_HI = 6'h0a;
    localparam logic [5:0] SMC_PART_NUM = 6'h15;
    localparam logic [3:0] SMC_REVISION = 4'h1;
    // Logic reset hold time after a clear, and clock loss timeout
    localparam int SMC_CLK_MHZ = 50;
    localparam int SMC_HOLD_NS = 100;
    localparam logic [3:0] SMC_HOLD_CYC = 4'((SMC_HOLD_NS * SMC_CLK_MHZ) / 1000);
    localparam logic [3:0] SMC_REF_TIMEOUT = 4'hf;

    typedef enum logic [2:0] {
        SMC_LB_NORMAL, SMC_LB_LOCAL, SMC_LB_LINE, SMC_LB_SPEC_LOCAL, SMC_LB_SPEC_LINE, SMC_LB_DIGITAL
    } smc_loop_mode_t;
    typedef enum logic [1:0] {SMC_PAT_COMPLIANCE_JITTER_PATTERN, SMC_PAT_PRWS, SMC_PAT_RESERVED} smc_pattern_t;

    typedef struct packed {
        logic rx_verify_en;
        logic tx_gen_en;
        logic rx_out_en;
        smc_pattern_t rx_pattern;
        smc_pattern_t tx_pattern;
    } smc_self_test_t;
endpackage

// ===== src/smc_logic_reset.sv
// Self-restoring logic reset channel for one reset bit
`timescale 1ns/1ns
module smc_logic_reset import smc_pkg::*; (
    input wire logic clock, // system clock
    input wire logic rst, // synchronous reset
    input wire logic clear_req, // pulse: software wrote 0
    input wire logic ref_ok, // reference clock present
    output logic bit_reg // readback and active-low logic reset
);
    logic [3:0] cnt_reg, cnt_next;
    logic bit_next;

    always_comb begin
        bit_next = bit_reg;
        cnt_next = cnt_reg;
        if (clear_req) begin
            bit_next = 1'b0;
            cnt_next = SMC_HOLD_CYC;
        end else if (!bit_reg && ref_ok) begin
            // Stuck in reset while the reference is missing
            if (cnt_reg <= 4'h1) begin
                bit_next = 1'b1;
            end else begin
                cnt_next = cnt_reg - 4'h1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            bit_reg <= 1'b1;
            cnt_reg <= 4'h0;
        end else begin
            bit_reg <= bit_next;
            cnt_reg <= cnt_next;
        end
    end

    property p_no_release_without_ref;
        @(posedge clock) disable iff (rst) (!bit_reg && !ref_ok && !clear_req) |=> !bit_reg;
    endproperty
    a_no_release_without_ref: assert property (p_no_release_without_ref) else $error("reset released early");
endmodule // smc_logic_reset

// ===== bench/smc_station.sv
// MDIO station model that sends management frames to the bank
`timescale 1ns/1ns
module smc_station import smc_pkg::*; (
    input wire logic clock, // system clock
    input wire logic line, // resolved management data line
    input wire logic dut_oe, // device drive enable
    output logic mdc, // management clock
    output logic st_out, // station data
    output logic st_oe // station drive enable
);
    initial begin
        mdc = 1'b0;
        st_out = 1'b1;
        st_oe = 1'b0;
    end
    // Data moves with falling mdc and is sampled at rising mdc; each half is 4 clocks
    task automatic bit_io(input logic drv, input logic val, output logic smp);
        @(negedge clock);
        mdc <= 1'b0;
        st_oe <= drv;
        st_out <= val;
        repeat (4) @(negedge clock);
        mdc <= 1'b1;
        smp = line;
        repeat (3) @(negedge clock);
    endtask
    task automatic frame(input logic rd, input logic [4:0] port, input logic [4:0] dev, input logic [4:0] ra,
                         input logic [15:0] wd, output logic [15:0] rdat, output logic ta_ok);
        logic [18:0] hdr;
        logic s;
        hdr = {SMC_START, rd ? SMC_OP_READ : SMC_OP_WRITE, port, dev, ra};
        for (int i = 18; i >= 0; i--) bit_io(1'b1, hdr[i], s);
        bit_io(!rd, 1'b1, s);
        ta_ok = !(rd && dut_oe);
        bit_io(!rd, 1'b0, s);
        ta_ok = ta_ok && !(rd && s !== 1'b0);
        for (int i = 15; i >= 0; i--) begin
            bit_io(!rd, wd[i], s);
            rdat[i] = s;
        end
        // Line released after the frame; the pull-up takes it high
        @(negedge clock);
        st_oe <= 1'b0;
    endtask
endmodule // smc_station

// ===== bench/smc_mgmt_regs_tb.sv
// Testbench for the serdes management register bank
`timescale 1ns/1ns
module smc_mgmt_regs_tb import smc_pkg::*; ;
    localparam logic [15:0] ID3 = {SMC_VENDOR_HI, SMC_PART_NUM, SMC_REVISION};
    localparam logic [4:0] OFS [10] = '{5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0e, 5'h0f};
    localparam logic [15:0] MSK [10] = '{16'hffff, 16'hffff, 16'h0101, 16'h8003, 16'hff03, 16'h000f, 16'hc000,
                                         16'h0733, 16'hffff, 16'hffff};
    localparam logic [15:0] DEF [10] = '{SMC_VENDOR_ID, ID3, 16'h0101, 16'h0000, 16'h2000, 16'h0000, 16'h8000,
                                         16'h0000, SMC_VENDOR_ID, ID3};
    logic clock = 1'b0, rst = 1'b1, pin_n = 1'b1, ref_clk = 1'b0, ref_on = 1'b1;
    logic mdc, st_out, st_oe, dut_out, dut_oe, line, rx_n, tx_n, fl_bypass, rx_oe_pins;
    logic [1:0] eq_pins = 2'b00, de_pins = 2'b00, rx_lvl, tx_lvl, seen;
    logic [7:0] hf_len;
    smc_loop_mode_t loop_mode;
    smc_self_test_t self_test;
    int n_errors = 0, n_checks = 0;
    assign line = dut_oe ? dut_out : (st_oe ? st_out : 1'b1);
    initial forever #10 clock = ~clock;
    always begin
        repeat (2) @(negedge clock);
        if (ref_on) ref_clk <= ~ref_clk;
    end
    always @(posedge clock) seen <= seen | ~{rx_n, tx_n};
    smc_mgmt_regs dut_u (.clock(clock), .rst(rst), .device_reset_pin_n(pin_n), .reference_input_clock(ref_clk),
        .mdc(mdc), .mdio_in(line), .mdio_out(dut_out), .mdio_oe(dut_oe), .equalization_select_pins(eq_pins),
        .deemphasis_select_pins(de_pins), .rx_logic_reset_n(rx_n), .tx_logic_reset_n(tx_n),
        .frame_loss_bypass(fl_bypass), .rx_equalization_level(rx_lvl), .tx_deemphasis_level(tx_lvl),
        .hyperframe_length(hf_len), .loop_mode(loop_mode), .self_test(self_test), .rx_parallel_out_en(rx_oe_pins));
    smc_station station_u (.clock(clock), .line(line), .dut_oe(dut_oe), .mdc(mdc), .st_out(st_out), .st_oe(st_oe));
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [4:0] ra, input logic [15:0] d, input logic [4:0] port = SMC_PORT_ADDR,
                      input logic [4:0] dev = SMC_DEV_ADDR);
        logic [15:0] r;
        logic t;
        station_u.frame(1'b0, port, dev, ra, d, r, t);
        repeat (3) @(negedge clock);
    endtask
    task automatic rd_chk(input logic [4:0] ra, input logic [15:0] m, input logic [15:0] e);
        logic [15:0] r;
        logic t;
        station_u.frame(1'b1, SMC_PORT_ADDR, SMC_DEV_ADDR, ra, 16'h0000, r, t);
        chk({15'h0, t}, 16'h0001);
        chk(r & m, e);
    endtask
    function automatic smc_loop_mode_t lb(input logic [3:0] c);
        if (c[0]) return SMC_LB_LOCAL;
        if (c[1]) return SMC_LB_LINE;
        case (c)
            4'h8: return SMC_LB_SPEC_LOCAL;
            4'h4: return SMC_LB_SPEC_LINE;
            4'hc: return SMC_LB_DIGITAL;
            default: return SMC_LB_NORMAL;
        endcase
    endfunction
    function automatic smc_pattern_t pat(input logic [1:0] c);
        return (c == 2'b01) ? SMC_PAT_PRWS : ((c == 2'b10) ? SMC_PAT_RESERVED : SMC_PAT_COMPLIANCE_JITTER_PATTERN);
    endfunction
    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clock);
        n_errors++;
        finish_test();
    end
    initial begin
        logic [15:0] r;
        logic t;
        logic [1:0] c;
        repeat (20) @(negedge clock);
        rst = 1'b0;
        for (int i = 0; i < 10; i++) rd_chk(OFS[i], MSK[i], DEF[i]);
        chk(16'(hf_len), 16'h0020);
        $display("test defaults done");
        wr(SMC_OFS_RX_EQUALIZATION_LEVEL, 16'h8003);
        chk({fl_bypass, 13'h0, rx_lvl}, 16'h8003);
        eq_pins = 2'b01;
        wr(SMC_OFS_TX_DEEMPHASIS_LEVEL, 16'hab03);
        chk(16'(rx_lvl), 16'h0001);
        chk({hf_len, 6'h0, tx_lvl}, 16'hab03);
        de_pins = 2'b10;
        wr(SMC_OFS_MGMT_REQ, 16'h0000);
        wr(SMC_OFS_VENDOR_PART, 16'h0000);
        chk(16'(tx_lvl), 16'h0002);
        rd_chk(SMC_OFS_MGMT_REQ, 16'hc000, 16'h8000);
        rd_chk(SMC_OFS_VENDOR_PART_M, 16'hffff, ID3);
        $display("test fields done");
        for (int i = 0; i < 16; i++) begin
            wr(SMC_OFS_LOOPBACK, 16'(i));
            chk(16'(loop_mode), 16'(lb(4'(i))));
        end
        for (int k = 0; k < 4; k++) begin
            c = 2'(k);
            wr(SMC_OFS_SELF_TEST, {5'h0, c[0], c[1], c[0], 2'b0, c, 2'b0, ~c});
            chk(16'(self_test), 16'({c[1], c[0], c[0], pat(c), pat(~c)}));
            chk(16'(rx_oe_pins), 16'(c[0] & c[1]));
        end
        $display("test modes done");
        station_u.frame(1'b1, 5'h02, SMC_DEV_ADDR, SMC_OFS_VENDOR_ID, 16'h0000, r, t);
        chk(r, SMC_ALL_ONES);
        station_u.frame(1'b1, SMC_PORT_ADDR, 5'h1f, SMC_OFS_VENDOR_ID, 16'h0000, r, t);
        chk(r, SMC_ALL_ZEROS);
        wr(SMC_OFS_LOOPBACK, 16'h0000, 5'h02);
        wr(SMC_OFS_LOOPBACK, 16'h0000, SMC_PORT_ADDR, 5'h1f);
        chk(16'(loop_mode), 16'(SMC_LB_LOCAL));
        $display("test addressing done");
        seen = 2'b00;
        wr(SMC_OFS_RESET, 16'h0001);
        repeat (20) @(negedge clock);
        chk({seen, rx_n, tx_n}, 16'h000b);
        rd_chk(SMC_OFS_RESET, 16'h0101, 16'h0101);
        seen = 2'b00;
        wr(SMC_OFS_RESET, 16'h0100);
        repeat (20) @(negedge clock);
        chk({seen, rx_n, tx_n}, 16'h0007);
        ref_on = 1'b0;
        repeat (20) @(negedge clock);
        wr(SMC_OFS_RESET, 16'h0000);
        repeat (40) @(negedge clock);
        chk({rx_n, tx_n}, 16'h0000);
        rd_chk(SMC_OFS_RESET, 16'h0101, 16'h0000);
        ref_on = 1'b1;
        repeat (40) @(negedge clock);
        rd_chk(SMC_OFS_RESET, 16'h0101, 16'h0101);
        $display("test logic resets done");
        pin_n = 1'b0;
        repeat (2) @(negedge clock);
        pin_n = 1'b1;
        repeat (2) @(negedge clock);
        chk({hf_len, 6'h0, fl_bypass, self_test.tx_gen_en}, 16'h2000);
        rd_chk(SMC_OFS_LOOPBACK, 16'h000f, 16'h0000);
        $display("test pin reset done");
        finish_test();
    end
endmodule // smc_mgmt_regs_tb
